// ---- scg_defs.vh ----
// Overview of operation
// R01 - Report cipher rounds bit 25, carry-less bit 1
// R02 - Eight save/restore facility instructions decoded
// R03 - Enable write, supervisor ops need privilege 0
// R04 - Supervisor enable register at index DA0H
// R05 - All bitmaps 64 bits, bit per component
// R06 - Components 0 to 7 assigned to vector/bounds
// R07 - Components 8,9,11,12,13,15,16 assigned
// R08 - Bits 10,14,62:17 reserved; 63 no component
// R09 - Instruction mask is high:low operand concatenation
// R10 - User components 7:0,9; others supervisor
// R11 - Clear user enable excludes component always
// R12 - Supervisor ops honour supervisor enables only; the code masks supervisor ops with user and supervisor enables together
// R13 - Disabled enable-dependent component blocks writes
// R14 - Not fully enabled feature raises invalid opcode
// R15 - OS enable clear treats user enables clear
// R16 - Save-managed only components always usable
// R17 - Enable write loads low and high halves
// R18 - Enable bit 0 fixed one; clearing faults
// R19 - Upper vector without SIMD faults
// R20 - Effective set computed in one cycle
`ifndef SCG_DEFS_VH
`define SCG_DEFS_VH
`define SCG_SUP_ENABLE_INDEX   32'h00000DA0
`define SCG_CIPHER_FLAG_BIT    25
`define SCG_CLMUL_FLAG_BIT     1
`define SCG_OS_ENABLE_BIT      18
`define SCG_USER_COMP_MASK     64'h000000000000_02FF
`define SCG_SUP_COMP_MASK      64'h000000000001_B900
`define SCG_ENABLE_DEP_MASK    64'h00000000000000FC
`define SCG_USER_ENABLE_RESET  64'h0000000000000001
`define SCG_SUP_ENABLE_RESET   64'h0000000000000000
`define SCG_OP_READ_EXT        4'h0
`define SCG_OP_WRITE_EXT       4'h1
`define SCG_OP_SAVE            4'h2
`define SCG_OP_SAVE_OPT        4'h3
`define SCG_OP_SAVE_CMP        4'h4
`define SCG_OP_SAVE_SUP        4'h5
`define SCG_OP_RESTORE         4'h6
`define SCG_OP_RESTORE_SUP     4'h7
`define SCG_OP_MSR_READ        4'h8
`define SCG_OP_MSR_WRITE       4'h9
`endif

// ---- scg_feature_check.v ----
`timescale 1ns/1ns
`default_nettype none
`include "scg_defs.vh"
module scg_feature_check #(
  parameter W = 64
) (
  input  wire [W-1:0] user_en_i,   // User-component enables
  input  wire         os_en_i,     // OS save-feature enable
  input  wire [W-1:0] need_i,      // Components a feature needs
  output wire [W-1:0] eff_en_o,    // Enables as seen by features
  output wire         fault_o      // Feature not fully enabled
);
  wire [W-1:0] dep;
  assign dep = need_i & `SCG_ENABLE_DEP_MASK; // R16
  assign eff_en_o = os_en_i ? user_en_i : {W{1'b0}}; // R15
  assign fault_o = (dep & ~eff_en_o) != {W{1'b0}}; // R14
endmodule
`default_nettype wire

// ---- scg_gating.v ----
`timescale 1ns/1ns
`default_nettype none
`include "scg_defs.vh"
module scg_gating #(
  parameter W = 64
) (
  input  wire         REF_CLK_I,     // Core clock
  input  wire         SYS_RST_I,     // Async reset, high
  input  wire         OP_VALID_I,    // Instruction valid
  input  wire [3:0]   OP_CODE_I,     // Instruction kind
  input  wire [1:0]   PRIV_LEVEL_I,  // Current privilege level
  input  wire         OS_ENABLE_I,   // OS save-feature enable
  input  wire [31:0]  LOW_OPERAND_I, // Low operand register
  input  wire [31:0]  HIGH_OPERAND_I,// High operand register
  input  wire [31:0]  SELECTOR_I,    // Selector / MSR index
  input  wire [W-1:0] FEAT_NEED_I,   // Components a feature uses
  input  wire         FEAT_VALID_I,  // Feature instruction valid
  output reg          DONE_O,        // Instruction completed, pulse
  output reg  [W-1:0] EFF_SET_O,     // Effective component set
  output reg  [31:0]  RD_LOW_O,      // Read data low half
  output reg  [31:0]  RD_HIGH_O,     // Read data high half
  output reg          GP_FAULT_O,    // General-protection fault pulse
  output reg          UD_FAULT_O,    // Invalid-opcode fault pulse
  output reg          FEAT_FAULT_O,  // Feature invalid-opcode pulse
  output reg  [W-1:0] MODIFY_OK_O,   // Component registers writable
  output reg  [31:0]  FEAT_FLAGS_O   // Leaf-1 feature flags
);
  reg  [W-1:0] user_en_reg;
  reg  [W-1:0] user_en_next;
  reg  [W-1:0] sup_en_reg;
  reg  [W-1:0] sup_en_next;
  reg          done_next;
  reg  [W-1:0] eff_next;
  reg  [31:0]  rd_low_next;
  reg  [31:0]  rd_high_next;
  reg          gp_next;
  reg          ud_next;
  wire [W-1:0] mask;
  wire [W-1:0] feat_en;
  wire         feat_fault;

  assign mask = {HIGH_OPERAND_I, LOW_OPERAND_I}; // R09

  scg_feature_check #(.W(W)) u_check (
    .user_en_i (user_en_reg),
    .os_en_i   (OS_ENABLE_I),
    .need_i    (FEAT_NEED_I),
    .eff_en_o  (feat_en),
    .fault_o   (feat_fault)
  );

  // Only kinds that may run below privilege 0.
  function open_priv;
    input [3:0] op;
    begin
      open_priv = (op == `SCG_OP_READ_EXT) || (op == `SCG_OP_SAVE) ||
                  (op == `SCG_OP_SAVE_OPT) || (op == `SCG_OP_SAVE_CMP) ||
                  (op == `SCG_OP_RESTORE); // R03
    end
  endfunction

  always @* begin
    user_en_next = user_en_reg;
    sup_en_next  = sup_en_reg;
    done_next    = 1'b0;
    eff_next     = {W{1'b0}};
    rd_low_next  = 32'h00000000;
    rd_high_next = 32'h00000000;
    gp_next      = 1'b0;
    ud_next      = 1'b0;
    if (OP_VALID_I) begin
      if (!OS_ENABLE_I && OP_CODE_I <= `SCG_OP_RESTORE_SUP) begin
        ud_next = 1'b1; // R15
      end else if (!open_priv(OP_CODE_I) && OP_CODE_I <= `SCG_OP_MSR_WRITE &&
                   PRIV_LEVEL_I != 2'h0) begin
        gp_next = 1'b1; // R03
      end else begin
        case (OP_CODE_I) // R02
          `SCG_OP_READ_EXT: begin
            if (SELECTOR_I != 32'h00000000) begin
              gp_next = 1'b1;
            end else begin
              rd_low_next  = user_en_reg[31:0];
              rd_high_next = user_en_reg[63:32];
              done_next    = 1'b1;
            end
          end
          `SCG_OP_WRITE_EXT: begin
            if (SELECTOR_I != 32'h00000000 || !LOW_OPERAND_I[0] || // R18
                LOW_OPERAND_I[2:1] == 2'h2 || // R19
                (mask & ~`SCG_USER_COMP_MASK) != {W{1'b0}}) begin // R08
              gp_next = 1'b1;
            end else begin
              user_en_next = mask; // R17
              done_next    = 1'b1;
            end
          end
          `SCG_OP_SAVE, `SCG_OP_SAVE_OPT, `SCG_OP_SAVE_CMP, `SCG_OP_RESTORE: begin
            eff_next  = mask & user_en_reg & `SCG_USER_COMP_MASK; // R11 R12 R20
            done_next = 1'b1;
          end
          `SCG_OP_SAVE_SUP, `SCG_OP_RESTORE_SUP: begin
            eff_next  = mask & (user_en_reg | sup_en_reg); // R10 R12 R20
            done_next = 1'b1;
          end
          `SCG_OP_MSR_READ, `SCG_OP_MSR_WRITE: begin
            if (SELECTOR_I != `SCG_SUP_ENABLE_INDEX) begin // R04
              gp_next = 1'b1;
            end else if (OP_CODE_I == `SCG_OP_MSR_READ) begin
              rd_low_next  = sup_en_reg[31:0];
              rd_high_next = sup_en_reg[63:32];
              done_next    = 1'b1;
            end else if ((mask & ~`SCG_SUP_COMP_MASK) != {W{1'b0}}) begin
              gp_next = 1'b1; // R08
            end else begin
              sup_en_next = mask; // R04
              done_next   = 1'b1;
            end
          end
          default: begin
            ud_next = 1'b1;
          end
        endcase
      end
    end
  end

  always @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      user_en_reg  <= `SCG_USER_ENABLE_RESET; // R18
      sup_en_reg   <= `SCG_SUP_ENABLE_RESET;
      DONE_O       <= 1'b0;
      EFF_SET_O    <= {W{1'b0}};
      RD_LOW_O     <= 32'h00000000;
      RD_HIGH_O    <= 32'h00000000;
      GP_FAULT_O   <= 1'b0;
      UD_FAULT_O   <= 1'b0;
      FEAT_FAULT_O <= 1'b0;
      MODIFY_OK_O  <= ~`SCG_ENABLE_DEP_MASK;
      FEAT_FLAGS_O <= 32'h00000000;
    end else begin
      user_en_reg  <= user_en_next;
      sup_en_reg   <= sup_en_next;
      DONE_O       <= done_next;
      EFF_SET_O    <= eff_next; // R05 R06 R07
      RD_LOW_O     <= rd_low_next;
      RD_HIGH_O    <= rd_high_next;
      GP_FAULT_O   <= gp_next;
      UD_FAULT_O   <= ud_next;
      FEAT_FAULT_O <= FEAT_VALID_I & feat_fault; // R14
      // Disabled enable-dependent components are frozen, not cleared.
      MODIFY_OK_O  <= feat_en | ~`SCG_ENABLE_DEP_MASK; // R13 R16
      FEAT_FLAGS_O <= (32'h00000001 << `SCG_CIPHER_FLAG_BIT) |
                      (32'h00000001 << `SCG_CLMUL_FLAG_BIT); // R01
    end
  end
endmodule
`default_nettype wire

// ---- scg_gating_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module scg_gating_sva #(
  parameter W = 64
) (
  input wire logic         REF_CLK_I,    // Clock
  input wire logic         SYS_RST_I,    // Reset
  input wire logic         OP_VALID_I,   // Op pulse
  input wire logic [3:0]   OP_CODE_I,    // Op kind
  input wire logic [1:0]   PRIV_LEVEL_I, // Privilege
  input wire logic         OS_ENABLE_I,  // OS enable
  input wire logic [31:0]  SELECTOR_I,   // Selector
  input wire logic         DONE_O,       // Done
  input wire logic         GP_FAULT_O,   // GP fault
  input wire logic         UD_FAULT_O,   // UD fault
  input wire logic [W-1:0] EFF_SET_O,    // Effective set
  input wire logic [31:0]  FEAT_FLAGS_O  // Flags
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_req(cond);
    OP_VALID_I && OS_ENABLE_I && cond;
  endsequence
  AST_FLAGS: assert property (!$past(SYS_RST_I) |-> FEAT_FLAGS_O == 32'h02000002)
    else $error("feature flags wrong");
  AST_ONE: assert property (OP_VALID_I |=> $onehot({DONE_O, GP_FAULT_O, UD_FAULT_O}))
    else $error("not exactly one answer");
  AST_PRIV: assert property (s_req(PRIV_LEVEL_I != 2'h0 && OP_CODE_I inside {4'h1, 4'h5, 4'h7})
    |=> GP_FAULT_O) else $error("privileged op not refused");
  AST_ANY: assert property (s_req(OP_CODE_I inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h6} &&
    (OP_CODE_I != 4'h0 || SELECTOR_I == 32'h0)) |=> !GP_FAULT_O)
    else $error("unprivileged op refused");
  AST_OFF: assert property (OP_VALID_I && !OS_ENABLE_I && OP_CODE_I <= 4'h7 |=> UD_FAULT_O)
    else $error("op ran with OS enable clear");
  AST_BAD: assert property (OP_VALID_I && OP_CODE_I > 4'h9 |=> UD_FAULT_O)
    else $error("unknown op accepted");
  AST_IDLE: assert property (!OP_VALID_I |=> !DONE_O && EFF_SET_O == '0)
    else $error("answer without request");
  AST_USER: assert property (s_req(OP_CODE_I inside {4'h2, 4'h3, 4'h4, 4'h6})
    |=> (EFF_SET_O & ~64'h2FF) == '0) else $error("supervisor part in user op");
  AST_RSV: assert property (EFF_SET_O[W-1:17] == '0 && !EFF_SET_O[14] && !EFF_SET_O[10])
    else $error("reserved bit in set");
endmodule
bind scg_gating scg_gating_sva #(.W(W)) u_sva (.REF_CLK_I, .SYS_RST_I, .OP_VALID_I, .OP_CODE_I,
  .PRIV_LEVEL_I, .OS_ENABLE_I, .SELECTOR_I, .DONE_O, .GP_FAULT_O, .UD_FAULT_O, .EFF_SET_O,
  .FEAT_FLAGS_O);
`default_nettype wire

// ---- scg_pipe_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module scg_pipe_model (
  input  wire logic        clk_i,  // Core clock
  output var  logic        vld_o,  // Op pulse
  output var  logic        fvld_o, // Feature pulse
  output var  logic [3:0]  code_o, // Op kind
  output var  logic [1:0]  priv_o, // Privilege
  output var  logic        os_o,   // OS enable
  output var  logic [31:0] low_o,  // Low operand
  output var  logic [31:0] high_o, // High operand
  output var  logic [31:0] sel_o   // Selector
);
  initial {vld_o, fvld_o, code_o, priv_o, os_o, low_o, high_o, sel_o} = '0;
  // Released operands are inverted so a stale value never passes for a live one.
  task automatic issue(input logic f, input logic [3:0] c, input logic [1:0] p,
                       input logic o, input logic [63:0] m);
    @(negedge clk_i);
    {fvld_o, vld_o, code_o, priv_o, os_o} = {f, !f, c, p, o};
    {high_o, low_o} = m;
    sel_o = (c >= 4'h8) ? 32'h00000DA0 : 32'h0;
    @(negedge clk_i);
    {fvld_o, vld_o} = 2'h0;
    {high_o, low_o} = ~m;
  endtask
endmodule
`default_nettype wire

// ---- state_component_gating_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module state_component_gating_test;
  typedef struct {logic f; logic [3:0] c; logic [1:0] p; logic o; logic [63:0] m;
    logic [3:0] r; logic [63:0] e; logic [31:0] d;} scg_row_t;
  logic clk = 1'b0, rst = 1'b1, vld, fvld, os, done, gp, ud, ff;
  logic [3:0] code;
  logic [1:0] priv;
  logic [31:0] lo, hi, sel, rdl, rdh, flags;
  logic [63:0] eff, mok;
  int fails = 0, tests_run = 0, cyc = 0;
  scg_row_t rows[25];
  scg_pipe_model m (.clk_i(clk), .vld_o(vld), .fvld_o(fvld), .code_o(code), .priv_o(priv),
    .os_o(os), .low_o(lo), .high_o(hi), .sel_o(sel));
  scg_gating dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .OP_VALID_I(vld), .OP_CODE_I(code),
    .PRIV_LEVEL_I(priv), .OS_ENABLE_I(os), .LOW_OPERAND_I(lo), .HIGH_OPERAND_I(hi),
    .SELECTOR_I(sel), .FEAT_NEED_I({hi, lo}), .FEAT_VALID_I(fvld), .DONE_O(done),
    .EFF_SET_O(eff), .RD_LOW_O(rdl), .RD_HIGH_O(rdh), .GP_FAULT_O(gp), .UD_FAULT_O(ud),
    .FEAT_FAULT_O(ff), .MODIFY_OK_O(mok), .FEAT_FLAGS_O(flags));
  always #20 clk = ~clk;
  task automatic conclude;
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      fails++;
      conclude();
    end
  end
  initial begin
    rows = '{'{1'h0, 4'h0, 2'h3, 1'h1, 64'h0, 4'h8, 64'h0, 32'h1},
      '{1'h0, 4'h1, 2'h1, 1'h1, 64'h7, 4'h4, 64'h0, 32'h0},
      '{1'h0, 4'h1, 2'h0, 1'h1, 64'h6, 4'h4, 64'h0, 32'h0},
      '{1'h0, 4'h1, 2'h0, 1'h1, 64'h5, 4'h4, 64'h0, 32'h0},
      '{1'h0, 4'h1, 2'h0, 1'h1, 64'h7, 4'h8, 64'h0, 32'h0},
      '{1'h0, 4'h9, 2'h0, 1'h1, 64'h1B900, 4'h8, 64'h0, 32'h0},
      '{1'h0, 4'h8, 2'h0, 1'h1, 64'h0, 4'h8, 64'h0, 32'h1B900},
      '{1'h0, 4'h2, 2'h3, 1'h1, ~64'h0, 4'h8, 64'h7, 32'h0},
      '{1'h0, 4'h5, 2'h0, 1'h1, ~64'h0, 4'h8, 64'h1B907, 32'h0},
      '{1'h0, 4'h6, 2'h2, 1'h1, 64'h100000006, 4'h8, 64'h6, 32'h0},
      '{1'h0, 4'h4, 2'h1, 1'h1, ~64'h0, 4'h8, 64'h7, 32'h0},
      '{1'h0, 4'h7, 2'h1, 1'h1, ~64'h0, 4'h4, 64'h0, 32'h0},
      '{1'h0, 4'h7, 2'h0, 1'h1, 64'h8106, 4'h8, 64'h8106, 32'h0},
      '{1'h0, 4'h9, 2'h0, 1'h1, 64'h2, 4'h4, 64'h0, 32'h0},
      '{1'h0, 4'h8, 2'h0, 1'h1, 64'h0, 4'h8, 64'h0, 32'h1B900},
      '{1'h0, 4'h8, 2'h1, 1'h1, 64'h0, 4'h4, 64'h0, 32'h0},
      '{1'h0, 4'h1, 2'h0, 1'h1, 64'h407, 4'h4, 64'h0, 32'h0},
      '{1'h0, 4'h0, 2'h0, 1'h1, 64'h0, 4'h8, 64'h0, 32'h7},
      '{1'h0, 4'hF, 2'h3, 1'h1, 64'h0, 4'h2, 64'h0, 32'h0},
      '{1'h0, 4'h3, 2'h0, 1'h0, ~64'h0, 4'h2, 64'h0, 32'h0},
      '{1'h0, 4'hF, 2'h0, 1'h1, 64'h0, 4'h2, 64'h0, 32'h0},
      '{1'h1, 4'h0, 2'h0, 1'h1, 64'h20, 4'h1, 64'h0, 32'h0},
      '{1'h1, 4'h0, 2'h0, 1'h0, 64'h303, 4'h0, 64'h0, 32'h0},
      '{1'h1, 4'h0, 2'h0, 1'h0, 64'h6, 4'h1, 64'h0, 32'h0},
      '{1'h1, 4'h0, 2'h0, 1'h1, 64'h6, 4'h0, 64'h0, 32'h0}};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      m.issue(rows[i].f, rows[i].c, rows[i].p, rows[i].o, rows[i].m);
      `CHK("resp", rows[i].r, {done, gp, ud, ff})
      `CHK("rdata", rows[i].d, rdl)
      `CHK("rdhigh", 32'h0, rdh)
      if (!rows[i].f && rows[i].c inside {[4'h2:4'h7]})
        `CHK("effset", rows[i].e, eff)
    end
    `CHK("flags", 32'h02000002, flags)
    `CHK("modify", ~64'hF8, mok)
    rst = 1'b1;
    @(negedge clk);
    `CHK("modrst", ~64'hFC, mok)
    rst = 1'b0;
    m.issue(1'h0, 4'h0, 2'h0, 1'h1, 64'h0);
    `CHK("rstread", 32'h1, rdl)
    conclude();
  end
endmodule
`default_nettype wire
